/* rtl/smdsu_unit.v */
// signed multiply, divide and shift execution datapath
`timescale 1ns/1ps
`include "smdsu_regs.vh"
module smdsu_unit
(
   input wire core_clk,
   input wire arst_n,
   input wire issue,
   input wire [15:0] opWord,
   input wire extPrefix,
   input wire [31:0] dstValue,
   input wire [31:0] srcValue,
   input wire [7:0] flagsIn,
   output wire issueReady,
   output wire [3:0] srcNum,
   output wire [3:0] dstNum,
   output wire opLegal,
   output reg done,
   output reg dstWrite,
   output reg srcWrite,
   output reg flagsWrite,
   output reg [3:0] dstIndex,
   output reg [3:0] srcIndex,
   output reg [31:0] dstResult,
   output reg [31:0] srcResult,
   output reg [7:0] flagsOut,
   output reg divZeroExc
);
   localparam ST_IDLE = 2'h0;
   localparam ST_DIV = 2'h1;
   localparam ST_WAIT = 2'h2;

   wire [2:0] opKind;
   wire useImm;
   wire [4:0] immCount;
   reg [1:0] state;
   reg [31:0] dividendHeld;
   reg [31:0] divisorHeld;
   reg [7:0] flagsHeld;
   reg [3:0] dstHeld;
   reg [3:0] srcHeld;
   reg divStart;
   wire divBusy;
   wire divDone;
   wire [31:0] quotMag;
   wire [31:0] remMag;

   ////////////////////////////////////////////////////////////////////////////////
   // decode and divider

   smdsu_decode decoder
   (
      .opWord(opWord),
      .extPrefix(extPrefix),
      .opKind(opKind),
      .useImm(useImm),
      .immCount(immCount),
      .srcNum(srcNum),
      .dstNum(dstNum),
      .legal(opLegal)
   );

   // magnitudes of the held divide operands
   wire dividendNeg = dividendHeld[31];
   wire divisorNeg = divisorHeld[31];
   wire [31:0] dividendMag = dividendNeg ? (32'h0 - dividendHeld) : dividendHeld;
   wire [31:0] divisorMag = divisorNeg ? (32'h0 - divisorHeld) : divisorHeld;

   smdsu_divider divider
   (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .start(divStart),
      .dividendMag(dividendMag),
      .divisorMag(divisorMag),
      .busy(divBusy),
      .done(divDone),
      .quotMag(quotMag),
      .remMag(remMag)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // single-cycle datapaths

   // shift results and carry for both directions, spill for the left shift only
   reg [4:0] shiftAmt;
   reg [63:0] leftWide;
   reg [31:0] sllResult;
   reg [31:0] sllSpill;
   reg sllCarry;
   reg [63:0] rightArith;
   reg [31:0] sraResult;
   reg sraCarry;
   always @*
   begin
      // count from the immediate field or source bits 4:0
      shiftAmt = useImm ? immCount : srcValue[4:0];
      // left: bits leaving the top land in the upper half
      leftWide = {32'h0, dstValue} << shiftAmt;
      sllResult = leftWide[31:0];
      sllSpill = leftWide[63:32];
      // right: sign copied down from bit 31
      rightArith = $signed({dstValue, 32'h0}) >>> shiftAmt;
      sraResult = rightArith[63:32];
      // a zero count shifts nothing out, so carry keeps its value
      if (shiftAmt == 5'h0)
      begin
         sllCarry = flagsIn[`SMDSU_FLAG_C];
         sraCarry = flagsIn[`SMDSU_FLAG_C];
      end
      else
      begin
         sllCarry = leftWide[32];
         sraCarry = rightArith[31];
      end
   end

   // signed product
   wire [63:0] product = $signed(dstValue) * $signed(srcValue);

   // combinational shift/multiply result and flags
   reg [31:0] nextDst;
   reg [31:0] nextSrc;
   reg nextSrcWrite;
   reg [7:0] nextFlags;
   always @*
   begin
      nextDst = 32'h0;
      nextSrc = 32'h0;
      nextSrcWrite = 1'b0;
      nextFlags = flagsIn;
      case (opKind)
         3'h2:
         begin
            nextDst = product[31:0];
            nextSrc = product[63:32];
            nextSrcWrite = 1'b1;
            nextFlags[`SMDSU_FLAG_Z] = (product == 64'h0);
            nextFlags[`SMDSU_FLAG_S] = product[63];
            nextFlags[`SMDSU_FLAG_V] = 1'b0;
            nextFlags[`SMDSU_FLAG_B] = 1'b0;
         end
         3'h3, 3'h4:
         begin
            nextDst = sllResult;
            nextSrc = sllSpill;
            nextSrcWrite = (opKind == 3'h4);
            nextFlags[`SMDSU_FLAG_C] = sllCarry;
            nextFlags[`SMDSU_FLAG_Z] = (sllResult == 32'h0);
            nextFlags[`SMDSU_FLAG_S] = sllResult[31];
            nextFlags[`SMDSU_FLAG_V] = sllCarry ^ sllResult[31];
            nextFlags[`SMDSU_FLAG_B] = 1'b0;
         end
         3'h5:
         begin
            nextDst = sraResult;
            nextFlags[`SMDSU_FLAG_C] = sraCarry;
            nextFlags[`SMDSU_FLAG_Z] = (sraResult == 32'h0);
            nextFlags[`SMDSU_FLAG_S] = sraResult[31];
            nextFlags[`SMDSU_FLAG_V] = sraCarry ^ sraResult[31];
            nextFlags[`SMDSU_FLAG_B] = 1'b0;
         end
         default:
         begin
            nextFlags = flagsIn;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // divide result assembly

   wire [31:0] quotSigned = (dividendNeg ^ divisorNeg) ? (32'h0 - quotMag) : quotMag;
   wire [31:0] remSigned = dividendNeg ? (32'h0 - remMag) : remMag;
   wire divSpecial = (dividendHeld == `SMDSU_MOST_NEG) && (divisorHeld == `SMDSU_MINUS_ONE);
   reg [31:0] divQuot;
   reg [31:0] divRem;
   reg [7:0] divFlags;
   always @*
   begin
      divQuot = divSpecial ? `SMDSU_MOST_NEG : quotSigned;
      divRem = divSpecial ? 32'h0 : remSigned;
      divFlags = flagsHeld;
      divFlags[`SMDSU_FLAG_Z] = (divQuot == 32'h0);
      divFlags[`SMDSU_FLAG_S] = divQuot[31];
      divFlags[`SMDSU_FLAG_V] = divSpecial;
      divFlags[`SMDSU_FLAG_B] = 1'b0;
   end

   assign issueReady = (state == ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // divide sequencing

   // next control state; only a divide with a nonzero divisor leaves idle
   reg [1:0] next_state;
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            // zero divisor and single-cycle ops finish without leaving idle
            if (issue && opLegal && opKind == 3'h1 && srcValue != 32'h0)
               next_state = ST_DIV;
         end
         ST_DIV:
         begin
            // start pulse seen by the divider, wait for its done
            if (divStart || divBusy)
               next_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (divDone)
               next_state = ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control and write-back registers

   // results are registered; done marks the one commit cycle, or the zero-divisor exception cycle, which has no writes
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         done <= 1'b0;
         dstWrite <= 1'b0;
         srcWrite <= 1'b0;
         flagsWrite <= 1'b0;
         dstIndex <= 4'h0;
         srcIndex <= 4'h0;
         dstResult <= 32'h0;
         srcResult <= 32'h0;
         flagsOut <= 8'h0;
         divZeroExc <= 1'b0;
         dividendHeld <= 32'h0;
         divisorHeld <= 32'h0;
         flagsHeld <= 8'h0;
         dstHeld <= 4'h0;
         srcHeld <= 4'h0;
         divStart <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         dstWrite <= 1'b0;
         srcWrite <= 1'b0;
         flagsWrite <= 1'b0;
         divZeroExc <= 1'b0;
         divStart <= 1'b0;
         state <= next_state;
         case (state)
            ST_IDLE:
            begin
               if (issue && opLegal)
               begin
                  dstIndex <= dstNum;
                  srcIndex <= srcNum;
                  if (opKind == 3'h1)
                  begin
                     dividendHeld <= dstValue;
                     divisorHeld <= srcValue;
                     flagsHeld <= flagsIn;
                     dstHeld <= dstNum;
                     srcHeld <= srcNum;
                     if (srcValue == 32'h0)
                     begin
                        done <= 1'b1;
                        divZeroExc <= 1'b1;
                     end
                     else
                     begin
                        divStart <= 1'b1;
                     end
                  end
                  else
                  begin
                     done <= 1'b1;
                     dstWrite <= 1'b1;
                     srcWrite <= nextSrcWrite;
                     flagsWrite <= 1'b1;
                     dstResult <= nextDst;
                     srcResult <= nextSrc;
                     flagsOut <= nextFlags;
                  end
               end
            end
            ST_DIV:
            begin
               // start pulse to the divider, which is not busy yet; nothing to commit
            end
            ST_WAIT:
            begin
               if (divDone)
               begin
                  done <= 1'b1;
                  dstWrite <= 1'b1;
                  srcWrite <= 1'b1;
                  flagsWrite <= 1'b1;
                  dstIndex <= dstHeld;
                  srcIndex <= srcHeld;
                  dstResult <= divQuot;
                  srcResult <= divRem;
                  flagsOut <= divFlags;
               end
            end
            default:
            begin
               divStart <= 1'b0;
            end
         endcase
      end
   end
endmodule // smdsu_unit

/* rtl/smdsu_regs.vh */
// constants for the signed multiply, divide and shift unit
`ifndef SMDSU_REGS_VH
`define SMDSU_REGS_VH
`define SMDSU_OP_SIGNED_DIVIDE_HI 8'haf
`define SMDSU_OP_SIGNED_MULTIPLY_HI 8'hb1
`define SMDSU_OP_SLLR_HI 8'hb6
`define SMDSU_OP_SRAR_HI 8'hb4
`define SMDSU_OP_IMM_NIB 4'hb
`define SMDSU_SUB_SLL 3'h6
`define SMDSU_SUB_SRA 3'h4
`define SMDSU_EXT_PREFIX 16'h0007
`define SMDSU_MOST_NEG 32'h80000000
`define SMDSU_MINUS_ONE 32'hffffffff
`define SMDSU_FLAG_C 7
`define SMDSU_FLAG_Z 6
`define SMDSU_FLAG_S 5
`define SMDSU_FLAG_V 4
`define SMDSU_FLAG_B 3
`define SMDSU_DIV_BITS 6'h20
`endif

/* rtl/smdsu_decode.v */
// opcode decoder for the five instructions
`timescale 1ns/1ps
`include "smdsu_regs.vh"
module smdsu_decode
(
   input wire [15:0] opWord,
   input wire extPrefix,
   output reg [2:0] opKind,
   output reg useImm,
   output reg [4:0] immCount,
   output reg [3:0] srcNum,
   output reg [3:0] dstNum,
   output reg legal
);
   // opKind: 1 div, 2 mul, 3 sll, 4 shift_left_extended, 5 sra
   always @*
   begin
      opKind = 3'h0;
      useImm = 1'b0;
      legal = 1'b1;
      immCount = opWord[8:4];
      srcNum = opWord[7:4];
      dstNum = opWord[3:0];
      if (opWord[15:8] == `SMDSU_OP_SIGNED_DIVIDE_HI)
         opKind = 3'h1;
      else if (opWord[15:8] == `SMDSU_OP_SIGNED_MULTIPLY_HI)
         opKind = 3'h2;
      else if (opWord[15:8] == `SMDSU_OP_SLLR_HI)
         opKind = extPrefix ? 3'h4 : 3'h3;
      else if (opWord[15:8] == `SMDSU_OP_SRAR_HI)
         opKind = 3'h5;
      else if (opWord[15:12] == `SMDSU_OP_IMM_NIB && opWord[11:9] == `SMDSU_SUB_SLL)
      begin
         opKind = 3'h3;
         useImm = 1'b1;
      end
      else if (opWord[15:12] == `SMDSU_OP_IMM_NIB && opWord[11:9] == `SMDSU_SUB_SRA)
      begin
         opKind = 3'h5;
         useImm = 1'b1;
      end
      else
         legal = 1'b0;
   end
endmodule // smdsu_decode

/* rtl/smdsu_divider.v */
// iterative restoring divider on magnitudes
`timescale 1ns/1ps
`include "smdsu_regs.vh"
module smdsu_divider
(
   input wire core_clk,
   input wire arst_n,
   input wire start,
   input wire [31:0] dividendMag,
   input wire [31:0] divisorMag,
   output reg busy,
   output reg done,
   output reg [31:0] quotMag,
   output reg [31:0] remMag
);
   reg [5:0] count;
   wire [32:0] trial;
   assign trial = {remMag, quotMag[31]} - {1'b0, divisorMag};
   // one quotient bit per clock
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         count <= 6'h0;
         quotMag <= 32'h0;
         remMag <= 32'h0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            busy <= 1'b1;
            count <= `SMDSU_DIV_BITS;
            quotMag <= dividendMag;
            remMag <= 32'h0;
         end
         else if (busy)
         begin
            if (trial[32])
            begin
               remMag <= {remMag[30:0], quotMag[31]};
               quotMag <= {quotMag[30:0], 1'b0};
            end
            else
            begin
               remMag <= trial[31:0];
               quotMag <= {quotMag[30:0], 1'b1};
            end
            count <= count - 6'h1;
            if (count == 6'h1)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // smdsu_divider

/* tb/smdsu_unit_properties.sv */
// port assertions for the multiply, divide and shift datapath
`timescale 1ns/1ps
module smdsu_unit_properties
(
   input wire core_clk,
   input wire arst_n,
   input wire issue,
   input wire issueReady,
   input wire [15:0] opWord,
   input wire extPrefix,
   input wire [31:0] srcValue,
   input wire [7:0] flagsIn,
   input wire opLegal,
   input wire done,
   input wire dstWrite,
   input wire srcWrite,
   input wire flagsWrite,
   input wire [7:0] flagsOut,
   input wire [31:0] dstResult,
   input wire divZeroExc
);
   logic taken;
   logic shiftOp;
   logic [7:0] hi;
   // accepted request and opcode class
   assign taken = issue && issueReady && opLegal;
   assign hi = opWord[15:8];
   assign shiftOp = opWord[15:12] == 4'hb && hi != 8'hb1;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // divide: busy stretch, then one commit
   sequence s_div_busy;
      (!done && !issueReady)[*8];
   endsequence
   sequence s_div_commit;
      done && dstWrite && srcWrite && flagsWrite;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_div_timing: assert property (taken && hi == 8'haf && srcValue != 0 |=> s_div_busy ##27 s_div_commit)
      else $error("divide completion timing wrong");
   a_zero_divisor: assert property (taken && hi == 8'haf && srcValue == 0 |=> divZeroExc)
      else $error("zero divisor without exception");
   a_exc_nowrite: assert property (divZeroExc |-> done && !dstWrite && !srcWrite && !flagsWrite)
      else $error("exception came with writes");
   a_fast_done: assert property (taken && hi != 8'haf |=> done && dstWrite && flagsWrite)
      else $error("single cycle op did not complete");
   a_mul_flags: assert property (taken && hi == 8'hb1 |=> srcWrite && flagsOut[7] == $past(flagsIn[7])
      && flagsOut[4:3] == 2'b00) else $error("multiply flags wrong");
   a_shift_flags: assert property (taken && shiftOp |=> flagsOut[3] == 1'b0
      && flagsOut[4] == (flagsOut[7] ^ flagsOut[5]) && flagsOut[5] == dstResult[31]
      && flagsOut[6] == (dstResult == 32'h0)) else $error("shift flags wrong");
   a_plain_keep: assert property (taken && shiftOp && !(extPrefix && hi == 8'hb6) |=> !srcWrite)
      else $error("plain shift wrote source");
   a_ext_source: assert property (taken && extPrefix && hi == 8'hb6 |=> srcWrite)
      else $error("extended shift left source alone");
   a_legal_decode: assert property (hi == 8'haf || hi == 8'hb1 || hi == 8'hb4 || hi == 8'hb6
      || (opWord[15:12] == 4'hb && (opWord[11:9] == 3'h6 || opWord[11:9] == 3'h4)) |-> opLegal)
      else $error("known opcode not legal");
   a_refuse_idle: assert property (issueReady && !(issue && opLegal) |=> !done)
      else $error("completion without request");
endmodule // smdsu_unit_properties

/* tb/smdsu_regfile_model.sv */
// register file and flag register behind the datapath
`timescale 1ns/1ps
module smdsu_regfile_model
(
   input wire core_clk,
   input wire [3:0] srcNum,
   input wire [3:0] dstNum,
   input wire dstWrite,
   input wire srcWrite,
   input wire flagsWrite,
   input wire [3:0] dstIndex,
   input wire [3:0] srcIndex,
   input wire [31:0] dstResult,
   input wire [31:0] srcResult,
   input wire [7:0] flagsOut,
   output wire [31:0] dstValue,
   output wire [31:0] srcValue,
   output wire [7:0] flagsIn
);
   logic [31:0] regs [0:15];
   logic [7:0] flags;
   initial
   begin
      foreach (regs[i]) regs[i] = 32'h0;
      flags = 8'h0;
   end
   // read ports follow the operand nibbles
   assign dstValue = regs[dstNum];
   assign srcValue = regs[srcNum];
   assign flagsIn = flags;
   // commit only on the write strobes
   always @(posedge core_clk)
   begin
      if (dstWrite) regs[dstIndex] <= dstResult;
      if (srcWrite) regs[srcIndex] <= srcResult;
      if (flagsWrite) flags <= flagsOut;
   end
endmodule // smdsu_regfile_model

/* tb/smdsu_unit_tb.sv */
// self-checking bench for the multiply, divide and shift datapath
`timescale 1ns/1ps
module smdsu_unit_tb;
   typedef struct {logic [15:0] op; logic ext; logic [31:0] d, s; logic [7:0] f;
      logic [31:0] ed, es; logic [7:0] ef; logic ex;} smdsu_vec_t;
   logic core_clk, arst_n, issue, extPrefix, seen, exc;
   logic [15:0] opWord;
   wire [31:0] dstValue, srcValue, dstResult, srcResult;
   wire [7:0] flagsIn, flagsOut;
   wire [3:0] srcNum, dstNum, dstIndex, srcIndex;
   wire issueReady, opLegal, done, dstWrite, srcWrite, flagsWrite, divZeroExc;
   int fails, checksDone, cycles;
   smdsu_vec_t vec [11];
   smdsu_unit uut (.core_clk, .arst_n, .issue, .opWord, .extPrefix, .dstValue, .srcValue,
      .flagsIn, .issueReady, .srcNum, .dstNum, .opLegal, .done, .dstWrite, .srcWrite,
      .flagsWrite, .dstIndex, .srcIndex, .dstResult, .srcResult, .flagsOut, .divZeroExc);
   smdsu_regfile_model rf (.core_clk, .srcNum, .dstNum, .dstWrite, .srcWrite, .flagsWrite,
      .dstIndex, .srcIndex, .dstResult, .srcResult, .flagsOut, .dstValue, .srcValue, .flagsIn);
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 1500)
      begin
         fails++;
         end_of_test;
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h got %h", name, exp, got);
      end
   endtask
   // issue one instruction and wait for its completion
   task automatic exec(input logic [15:0] op, input logic ext);
      int n;
      n = 0;
      @(posedge core_clk);
      issue <= 1'b1;
      opWord <= op;
      extPrefix <= ext;
      @(posedge core_clk);
      issue <= 1'b0;
      #1;
      while (done !== 1'b1 && n < 40)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      seen = (done === 1'b1);
      exc = divZeroExc;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // op, prefix, dst, src, flags, then expected dst, src, flags, exception
   initial
   begin
      vec[0] = '{16'haf54, 0, 32'hffffffe5, 32'h5, 8'h8b, 32'hfffffffb, 32'hfffffffe, 8'ha3, 0};
      vec[1] = '{16'haf21, 0, 32'h80000000, 32'hffffffff, 8'h00, 32'h80000000, 32'h0, 8'h30, 0};
      vec[2] = '{16'haf63, 0, 32'h1234, 32'h0, 8'h5c, 32'h1234, 32'h0, 8'h5c, 1};
      vec[3] = '{16'hb154, 0, 32'hffffffe5, 32'h5, 8'h80, 32'hffffff79, 32'hffffffff, 8'ha0, 0};
      vec[4] = '{16'hbc47, 0, 32'h7f37b2d3, 32'h9, 8'h00, 32'hf37b2d30, 32'h9, 8'ha0, 0};
      vec[5] = '{16'hb687, 1, 32'h7f37b2d3, 32'h4, 8'h00, 32'hf37b2d30, 32'h7, 8'ha0, 0};
      vec[6] = '{16'hb687, 0, 32'h7f37b2d3, 32'h4, 8'h00, 32'hf37b2d30, 32'h4, 8'ha0, 0};
      vec[7] = '{16'hb847, 0, 32'h8f37b2d3, 32'h9, 8'h03, 32'hf8f37b2d, 32'h9, 8'h33, 0};
      vec[8] = '{16'hb487, 0, 32'h7f37b2d3, 32'h4, 8'h80, 32'h07f37b2d, 32'h4, 8'h00, 0};
      vec[9] = '{16'hb687, 0, 32'h80000001, 32'h0, 8'h80, 32'h80000001, 32'h0, 8'ha0, 0};
      vec[10] = '{16'hb487, 0, 32'h80000000, 32'h3f, 8'h00, 32'hffffffff, 32'h3f, 8'h30, 0};
      arst_n = 1'b0;
      issue = 1'b0;
      opWord = 16'h0;
      extPrefix = 1'b0;
      fails = 0;
      checksDone = 0;
      cycles = 0;
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      // table of instructions, results read back from the register file
      foreach (vec[i])
      begin
         @(posedge core_clk);
         rf.regs[vec[i].op[3:0]] <= vec[i].d;
         rf.regs[vec[i].op[7:4]] <= vec[i].s;
         rf.flags <= vec[i].f;
         exec(vec[i].op, vec[i].ext);
         @(posedge core_clk);
         #1;
         chk("completion", 32'h1, 32'(seen));
         chk("exception", 32'(vec[i].ex), 32'(exc));
         chk("destination", vec[i].ed, rf.regs[vec[i].op[3:0]]);
         chk("source", vec[i].es, rf.regs[vec[i].op[7:4]]);
         chk("flags", 32'(vec[i].ef), 32'(rf.flags));
      end
      // unknown opcode gets no completion
      exec(16'h0000, 1'b0);
      chk("ignored", 32'h0, 32'(seen));
      end_of_test;
   end
endmodule // smdsu_unit_tb
bind smdsu_unit smdsu_unit_properties props (.core_clk, .arst_n, .issue, .issueReady, .opWord,
   .extPrefix, .srcValue, .flagsIn, .opLegal, .done, .dstWrite, .srcWrite, .flagsWrite,
   .flagsOut, .dstResult, .divZeroExc);
